// ==== rtl/ttg_top.sv ====
// Purpose: two-channel test tone source with AXI4-Lite control
// Assumes: sample_tick is a one-cycle strobe from logic on aclk
// Notes: a two-entry buffer absorbs stalls of the tone receiver
`timescale 1ns/100ps
`default_nettype none
module ttg_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic sample_tick,
    input wire logic [ttg_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ttg_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output ttg_pkg::ttg_pair_s tone_data,
    output logic tone_valid,
    input wire logic tone_ready
);

    logic aw_held, next_aw_held, w_held, next_w_held, do_wr;
    logic [7:0] wr_addr, next_wr_addr;
    logic [31:0] wr_data, next_wr_data;
    logic [3:0] wr_strb, next_wr_strb;
    logic next_awready, next_wready, next_bvalid;
    logic next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic [31:0] ctrl, const0, const1, sine0, sine1;
    logic [31:0] next_ctrl, next_const0, next_const1;
    logic [31:0] next_sine0, next_sine1;
    logic [15:0] lfsr, next_lfsr, prbs_half;
    logic [31:0] count, next_count, sine_s0, sine_s1;
    logic pend, next_pend, en, fire, can_push, pop;
    ttg_pkg::ttg_src_e src0, src1;
    ttg_pkg::ttg_pair_s gen, slot1, next_slot1, next_head;
    logic [1:0] buf_count, next_buf_count;
    logic next_tone_valid;

    // Byte-lane merge for writes
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a == ttg_pkg::CTRL_OFS || a == ttg_pkg::CONST0_OFS
            || a == ttg_pkg::CONST1_OFS || a == ttg_pkg::SINE0_OFS
            || a == ttg_pkg::SINE1_OFS || a == ttg_pkg::STATUS_OFS
            || a == ttg_pkg::COUNT_OFS;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Write channel; address and data may come in either order
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        next_wr_strb = wr_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_ctrl = ctrl;
        next_const0 = const0;
        next_const1 = const1;
        next_sine0 = sine0;
        next_sine1 = sine1;
        do_wr = aw_held && w_held && !bvalid;
        if (awvalid && awready) begin
            next_aw_held = 1'b1;
            next_wr_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_w_held = 1'b1;
            next_wr_data = wdata;
            next_wr_strb = wstrb;
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (do_wr) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = mapped(wr_addr) ? ttg_pkg::RESP_OKAY
                : ttg_pkg::RESP_SLVERR;
            // Status and count words ignore writes
            unique case (wr_addr)
                ttg_pkg::CTRL_OFS: next_ctrl = merge(ctrl, wr_data, wr_strb);
                ttg_pkg::CONST0_OFS: begin
                    next_const0 = merge(const0, wr_data, wr_strb);
                end
                ttg_pkg::CONST1_OFS: begin
                    next_const1 = merge(const1, wr_data, wr_strb);
                end
                ttg_pkg::SINE0_OFS: next_sine0 = merge(sine0, wr_data, wr_strb);
                ttg_pkg::SINE1_OFS: next_sine1 = merge(sine1, wr_data, wr_strb);
                default: ;
            endcase
        end
        // Hold both ready low until the response is gone
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
    end

    // Read channel, one cycle from address to data
    always_comb begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp = mapped(araddr) ? ttg_pkg::RESP_OKAY
                : ttg_pkg::RESP_SLVERR;
            unique case (araddr)
                ttg_pkg::CTRL_OFS: next_rdata = ctrl;
                ttg_pkg::CONST0_OFS: next_rdata = const0;
                ttg_pkg::CONST1_OFS: next_rdata = const1;
                ttg_pkg::SINE0_OFS: next_rdata = sine0;
                ttg_pkg::SINE1_OFS: next_rdata = sine1;
                ttg_pkg::STATUS_OFS: next_rdata = {14'h0000, buf_count, lfsr};
                ttg_pkg::COUNT_OFS: next_rdata = count;
                default: next_rdata = 32'h0000_0000;
            endcase
        end
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= ttg_pkg::RESP_OKAY;
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= ttg_pkg::RESP_OKAY;
            ctrl <= ttg_pkg::CTRL_RST;
            const0 <= ttg_pkg::CONST_RST;
            const1 <= ttg_pkg::CONST_RST;
            sine0 <= ttg_pkg::SINE_RST;
            sine1 <= ttg_pkg::SINE_RST;
        end else if (ce) begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
            wr_strb <= next_wr_strb;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            ctrl <= next_ctrl;
            const0 <= next_const0;
            const1 <= next_const1;
            sine0 <= next_sine0;
            sine1 <= next_sine1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sine channels, one per side
    ttg_sine u_sine0 (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .step(fire),
        .n(sine0[ttg_pkg::STEP_LSB +: 12]),
        .amp(sine0[ttg_pkg::AMP_LSB +: 16]),
        .len(ctrl[ttg_pkg::LEN_LSB +: 5]),
        .dither(lfsr[0]),
        .sample(sine_s0)
    );

    ttg_sine u_sine1 (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .step(fire),
        .n(sine1[ttg_pkg::STEP_LSB +: 12]),
        .amp(sine1[ttg_pkg::AMP_LSB +: 16]),
        .len(ctrl[ttg_pkg::LEN_LSB +: 5]),
        .dither(lfsr[8]),
        .sample(sine_s1)
    );

    // R3 source pick per channel
    function automatic logic [31:0] pick(input ttg_pkg::ttg_src_e s,
        input logic [31:0] dc, input logic [31:0] sn,
        input logic [15:0] half);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (s)
            ttg_pkg::SRC_DC: r = dc;
            ttg_pkg::SRC_PRBS: r = {half, half};
            ttg_pkg::SRC_SINE: r = sn;
            ttg_pkg::SRC_MUTE: r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    // Generator; a tick waits while the buffer is full
    always_comb begin
        en = ctrl[ttg_pkg::EN_BIT];
        src0 = ttg_pkg::ttg_src_e'(ctrl[ttg_pkg::SRC0_LSB +: 2]);
        src1 = ttg_pkg::ttg_src_e'(ctrl[ttg_pkg::SRC1_LSB +: 2]);
        can_push = buf_count != 2'h2;
        // R2 R14 one step per tick
        fire = pend && en && can_push;
        next_pend = en && (sample_tick || (pend && !fire));
        // R4 R8 shared offset half
        prbs_half = ttg_pkg::PRBS_OFFSET - lfsr;
        // R1 independent channel sources
        gen.left = pick(src0, const0, sine_s0, prbs_half);
        gen.right = pick(src1, const1, sine_s1, prbs_half);
        next_count = fire ? count + 32'h0000_0001 : count;
        // R7 Fibonacci feedback taps
        next_lfsr = lfsr;
        if (fire) begin
            next_lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        end
    end

    // R6 R9 16-bit seeded register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lfsr <= ttg_pkg::LFSR_INIT;
            pend <= 1'b0;
            count <= 32'h0000_0000;
        end else if (ce) begin
            lfsr <= next_lfsr;
            pend <= next_pend;
            count <= next_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Two-entry buffer; head drives the port directly
    always_comb begin
        pop = tone_valid && tone_ready;
        next_head = tone_data;
        next_slot1 = slot1;
        next_buf_count = buf_count;
        if (pop && fire) begin
            if (buf_count == 2'h2) begin
                next_head = slot1;
                next_slot1 = gen;
            end else begin
                next_head = gen;
            end
        end else if (pop) begin
            next_head = slot1;
            next_buf_count = buf_count - 2'h1;
        end else if (fire) begin
            if (buf_count == 2'h0) begin
                next_head = gen;
            end else begin
                next_slot1 = gen;
            end
            next_buf_count = buf_count + 2'h1;
        end
        next_tone_valid = next_buf_count != 2'h0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tone_data <= '0;
            slot1 <= '0;
            buf_count <= 2'h0;
            tone_valid <= 1'b0;
        end else if (ce) begin
            tone_data <= next_head;
            slot1 <= next_slot1;
            buf_count <= next_buf_count;
            tone_valid <= next_tone_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_dc_left;
        src0 == ttg_pkg::SRC_DC |-> gen.left == const0;
    endproperty
    a_dc_left: assert property (p_dc_left) // R3
        else $error("left constant not passed through");

    property p_chan_indep;
        src1 == ttg_pkg::SRC_DC |-> gen.right == const1;
    endproperty
    a_chan_indep: assert property (p_chan_indep) // R1
        else $error("right channel ignores its own setting");

    property p_prbs_pack;
        src0 == ttg_pkg::SRC_PRBS |-> gen.left[31:16] == gen.left[15:0]
            && 16'(gen.left[15:0] + lfsr) == ttg_pkg::PRBS_OFFSET;
    endproperty
    a_prbs_pack: assert property (p_prbs_pack) // R8
        else $error("noise sample not built from two offset copies");

    property p_prbs_shared;
        src0 == ttg_pkg::SRC_PRBS && src1 == ttg_pkg::SRC_PRBS
            |-> gen.left == gen.right;
    endproperty
    a_prbs_shared: assert property (p_prbs_shared) // R4
        else $error("channels see different noise words");

    property p_lfsr_step;
        fire && ce |=> lfsr == {$past(lfsr[14:0]),
            ^($past(lfsr) & ttg_pkg::LFSR_TAPS)};
    endproperty
    a_lfsr_step: assert property (p_lfsr_step) // R7
        else $error("noise register feedback wrong");

    property p_lfsr_hold;
        ce && !fire |=> $stable(lfsr);
    endproperty
    a_lfsr_hold: assert property (p_lfsr_hold) // R14
        else $error("noise register moved without a sample");

    property p_lfsr_live;
        lfsr != 16'h0000;
    endproperty
    a_lfsr_live: assert property (p_lfsr_live) // R6
        else $error("noise register locked at zero");

    property p_lfsr_seed;
        $rose(aresetn) |-> lfsr == ttg_pkg::LFSR_INIT;
    endproperty
    a_lfsr_seed: assert property (p_lfsr_seed) // R9
        else $error("noise register not seeded after reset");

    property p_tick_kept;
        ce && en && sample_tick |=> pend;
    endproperty
    a_tick_kept: assert property (p_tick_kept) // R2
        else $error("sample tick lost");

    sequence s_stall;
        tone_valid && !tone_ready && ce;
    endsequence
    sequence s_held;
        tone_valid && $stable(tone_data);
    endsequence
    property p_buf_hold;
        s_stall |=> s_held;
    endproperty
    a_buf_hold: assert property (p_buf_hold) // R2
        else $error("tone word changed while stalled");

endmodule
`default_nettype wire

// ==== rtl/ttg_pkg.sv ====
// Purpose: constants, types and carriers of the test tone generator
// Assumes: one 250 MHz clock; the sample strobe comes from local logic
// Notes: registers sit on an AXI4-Lite slave, one aligned word each
// Operation
// R1 - The generator has two output channels, each with its own source.
// R2 - Valid samples come out at any sample rate from 8 kHz to 384 kHz.
// R3 - Each channel can send its own fixed 32-bit value on every sample.
// R4 - One noise source feeds both channels, so both get the same words.
// R5 - Each channel can send a sine of its own frequency and amplitude.
// R6 - The noise source is a 16-bit linear feedback shift register.
// R7 - Its feedback is x^16 + x^14 + x^13 + x^11 + 1, external XOR form.
// R8 - A noise sample holds 2^14 minus the register in both 16-bit halves.
// R9 - The register starts at 0x0001 and repeats every 65535 steps.
// R10 - Sine values are read from a lookup table, not computed.
// R11 - The tone is the sample rate times N over 3072.
// R12 - Sine samples get dither at the LSB of the declared data length.
// R13 - The controller routes the tones by source select code 3. Here code 3 (SRC_MUTE) sends zero on that channel instead.
// R14 - The noise register steps once per output sample.
// R15 - The sine phase steps by N modulo 3072 and is scaled by amplitude.
package ttg_pkg;

    // Bus geometry
    localparam int ADDR_W = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CONST0_OFS = 8'h04;
    localparam logic [7:0] CONST1_OFS = 8'h08;
    localparam logic [7:0] SINE0_OFS = 8'h0C;
    localparam logic [7:0] SINE1_OFS = 8'h10;
    localparam logic [7:0] STATUS_OFS = 8'h14;
    localparam logic [7:0] COUNT_OFS = 8'h18;

    // Control fields
    localparam int EN_BIT = 0;
    localparam int SRC0_LSB = 4;
    localparam int SRC1_LSB = 6;
    localparam int LEN_LSB = 8;
    localparam int STEP_LSB = 0;
    localparam int AMP_LSB = 16;

    // Values after reset
    localparam logic [31:0] CTRL_RST = 32'h0000_0600;
    localparam logic [31:0] CONST_RST = 32'h0000_0000;
    localparam logic [31:0] SINE_RST = 32'h8000_0040;

    // Noise source
    localparam logic [15:0] LFSR_INIT = 16'h0001;
    localparam logic [15:0] LFSR_TAPS = 16'hB400;
    localparam logic [15:0] PRBS_OFFSET = 16'h4000;

    // Sine phase and table
    localparam logic [11:0] PHASE_MOD = 12'hC00;
    localparam logic [11:0] QUARTER = 12'h300;
    localparam logic [11:0] LUT_STEP = 12'h018;
    localparam logic [5:0] LUT_TOP = 6'h20;

    // Data length in slots and dither position
    localparam logic [4:0] SLOTS_16 = 5'h04;
    localparam logic [4:0] SLOTS_20 = 5'h05;
    localparam logic [4:0] DPOS_16 = 5'h10;
    localparam logic [4:0] DPOS_20 = 5'h0C;
    localparam logic [4:0] DPOS_24 = 5'h08;

    // Per-channel source selection
    typedef enum logic [1:0] {
        SRC_DC = 2'b00,
        SRC_PRBS = 2'b01,
        SRC_SINE = 2'b10,
        SRC_MUTE = 2'b11
    } ttg_src_e;

    // One stereo sample frame
    typedef struct packed {
        logic [31:0] right;
        logic [31:0] left;
    } ttg_pair_s;

endpackage

// ==== rtl/ttg_sine.sv ====
// Purpose: one sine channel, phase accumulator and quarter-wave table
// Assumes: step is a one-cycle pulse per output sample
// Notes: output is combinational from the phase register
`timescale 1ns/100ps
`default_nettype none
module ttg_sine (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic step,
    input wire logic [11:0] n,
    input wire logic [15:0] amp,
    input wire logic [4:0] len,
    input wire logic dither,
    output logic [31:0] sample
);

    // Quarter wave, 33 points, full scale at the end
    localparam logic [15:0] SINE_LUT [0:32] = '{
        16'h0000, 16'h0648, 16'h0C8C, 16'h12C8, 16'h18F9, 16'h1F1A,
        16'h2528, 16'h2B1F, 16'h30FB, 16'h36BA, 16'h3C56, 16'h41CE,
        16'h471C, 16'h4C3F, 16'h5133, 16'h55F5, 16'h5A82, 16'h5ED7,
        16'h62F1, 16'h66CF, 16'h6A6D, 16'h6DC9, 16'h70E2, 16'h73B5,
        16'h7641, 16'h7884, 16'h7A7C, 16'h7C29, 16'h7D89, 16'h7E9C,
        16'h7F61, 16'h7FD8, 16'h7FFF};

    logic [11:0] phase, next_phase;
    logic [11:0] n_mod, pos;
    logic [12:0] sum;
    logic [1:0] quad;
    logic [5:0] idx;
    logic signed [15:0] wave;
    logic signed [32:0] prod;
    logic [4:0] dpos;

    ////////////////////////////////////////////////////////////////////////
    // R11 R15 phase step modulo
    always_comb begin
        n_mod = (n >= ttg_pkg::PHASE_MOD) ? n - ttg_pkg::PHASE_MOD : n;
        sum = {1'b0, phase} + {1'b0, n_mod};
        next_phase = phase;
        if (step) begin
            if (sum >= {1'b0, ttg_pkg::PHASE_MOD}) begin
                next_phase = 12'(sum - {1'b0, ttg_pkg::PHASE_MOD});
            end else begin
                next_phase = sum[11:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase <= 12'h000;
        end else if (ce) begin
            phase <= next_phase;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // R10 table lookup by quadrant
    always_comb begin
        quad = 2'(phase / ttg_pkg::QUARTER);
        pos = phase - 12'(quad * ttg_pkg::QUARTER);
        idx = 6'(pos / ttg_pkg::LUT_STEP);
        // Odd quadrants read the table backwards
        if (quad[0]) begin
            idx = ttg_pkg::LUT_TOP - idx;
        end
        wave = $signed(SINE_LUT[idx]);
        if (quad[1]) begin
            wave = -wave;
        end
    end

    // R5 amplitude scaling
    assign prod = wave * $signed({1'b0, amp});

    // R12 dither position
    // Short lengths fall back to 16 bits, long or unknown to 24 bits
    always_comb begin
        if (len <= ttg_pkg::SLOTS_16) begin
            dpos = ttg_pkg::DPOS_16;
        end else if (len == ttg_pkg::SLOTS_20) begin
            dpos = ttg_pkg::DPOS_20;
        end else begin
            dpos = ttg_pkg::DPOS_24;
        end
        sample = (prod[31:0] & (32'hFFFF_FFFF << dpos))
            ^ ({31'h0000_0000, dither} << dpos);
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_phase_range;
        phase < ttg_pkg::PHASE_MOD;
    endproperty
    a_phase_range: assert property (p_phase_range) // R11
        else $error("sine phase left its 3072 range");

    property p_phase_step;
        step && ce |=> 32'(phase) == (32'($past(phase))
            + 32'($past(n_mod))) % 32'(ttg_pkg::PHASE_MOD);
    endproperty
    a_phase_step: assert property (p_phase_step) // R15
        else $error("sine phase did not advance by N");

    property p_dither_low;
        len <= ttg_pkg::SLOTS_16 |-> sample[15:0] == 16'h0000;
    endproperty
    a_dither_low: assert property (p_dither_low) // R12
        else $error("bits below a 16-bit sample are not clear");

    property p_lut_peak;
        amp == 16'hFFFF && phase == ttg_pkg::QUARTER
            |-> sample[31:17] == 15'h3FFF;
    endproperty
    a_lut_peak: assert property (p_lut_peak) // R10
        else $error("table peak not reached at quarter phase");

endmodule
`default_nettype wire

// ==== bench/ttg_sink.sv ====
// Purpose: tone receiver model, takes words promptly or slowly
// Assumes: stall and slow are set by the bench
// Notes: ready stays low through reset
`timescale 1ns/100ps
`default_nettype none
module ttg_sink (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic stall,
    input wire logic slow,
    output logic tone_ready
);
    logic toggle;
    ////////////////////////////////////////////////////////////////
    // Slow mode accepts every other cycle, to vary the spacing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            toggle <= 1'b0;
        end else begin
            toggle <= ~toggle;
        end
    end
    // routing is chosen upstream, this model only takes words
    assign tone_ready = aresetn && !stall && (!slow || toggle);
endmodule
`default_nettype wire

// ==== bench/ttg_top_tb.sv ====
// Purpose: self-checking bench of the test tone generator
// Assumes: sample ticks come from the bench, one cycle each
// Notes: noise words come from a local shift register model
`timescale 1ns/100ps
`default_nettype none
module ttg_top_tb;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] wd;
        logic [1:0] wr;
        logic [31:0] rd;
        logic [1:0] rr;
    } ttg_row_s;
    localparam logic [1:0] OK = ttg_pkg::RESP_OKAY;
    localparam logic [1:0] ER = ttg_pkg::RESP_SLVERR;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic sample_tick = 1'b0;
    logic [7:0] awaddr = '0;
    logic [7:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, stall = 1'b0, slow = 1'b0;
    logic ce = 1'b1;
    logic awready, wready, bvalid, arready, rvalid, tone_valid, tone_ready;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    ttg_pkg::ttg_pair_s tone_data, w, w2;
    logic [15:0] s, t;
    int error_cnt = 0;
    int cmp_count = 0;
    ttg_row_s rows[5] = '{
        '{ttg_pkg::CONST0_OFS, 32'h1234_5678, OK, 32'h1234_5678, OK},
        '{ttg_pkg::CONST1_OFS, 32'h89AB_CDEF, OK, 32'h89AB_CDEF, OK},
        '{ttg_pkg::SINE1_OFS, 32'h0100_0020, OK, 32'h0100_0020, OK},
        '{ttg_pkg::COUNT_OFS, 32'hFFFF_FFFF, OK, 32'h0000_0000, OK},
        '{8'h1C, 32'h5555_AAAA, ER, 32'h0000_0000, ER}};
    always #2 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////
    ttg_top ttg_top_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .sample_tick(sample_tick), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .tone_data(tone_data), .tone_valid(tone_valid),
        .tone_ready(tone_ready));
    ttg_sink ttg_sink_inst (.aclk(aclk), .aresetn(aresetn), .stall(stall),
        .slow(slow), .tone_ready(tone_ready));
    ////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bound(input int n);
        if (n >= 60) begin
            chk(64'h0, 64'h1);
            print_verdict();
        end
    endtask
    // Master holds each channel until its own handshake edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        output logic [1:0] r);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        r = bresp;
        bready <= 1'b0;
        bound(n);
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        bound(n);
        @(posedge aclk);
    endtask
    task automatic tick();
        sample_tick <= 1'b1;
        @(posedge aclk);
        sample_tick <= 1'b0;
    endtask
    task automatic take(output ttg_pkg::ttg_pair_s o);
        int n;
        for (n = 0; n < 60; n++) begin
            @(posedge aclk);
            if (tone_valid === 1'b1 && tone_ready === 1'b1) break;
        end
        o = tone_data;
        bound(n);
    endtask
    task automatic rst();
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    // Noise model: left shift, feedback from taps 16, 14, 13, 11
    function automatic logic [15:0] nx(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic [63:0] nz(input logic [15:0] v);
        logic [15:0] h;
        h = 16'h4000 - v;
        return {h, h, h, h};
    endfunction
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        rst();
        // Register writes and read-back, unmapped place included
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].wd, r);
            chk({62'h0, r}, {62'h0, rows[i].wr});
            rd(rows[i].a, d, r);
            chk({30'h0, r, d}, {30'h0, rows[i].rr, rows[i].rd});
        end
        slow <= 1'b1;
        wr(ttg_pkg::CTRL_OFS, 32'h0000_0601, r);
        tick();
        take(w);
        chk(w, 64'h89AB_CDEF_1234_5678);
        // Second reset: defaults come back, noise restarts at one
        rst();
        rd(ttg_pkg::SINE0_OFS, d, r);
        chk({32'h0, d}, {32'h0, ttg_pkg::SINE_RST});
        rd(ttg_pkg::STATUS_OFS, d, r);
        chk({32'h0, d}, 64'h0000_0000_0000_0001);
        s = 16'h0001;
        wr(ttg_pkg::CTRL_OFS, 32'h0000_0651, r);
        tick();
        take(w);
        chk(w, nz(s));
        s = nx(s);
        // Stalled receiver: two stored, the third tick waits
        stall <= 1'b1;
        repeat (3) begin
            tick();
            repeat (4) @(posedge aclk);
        end
        t = nx(nx(s));
        rd(ttg_pkg::STATUS_OFS, d, r);
        chk({32'h0, d}, {46'h0, 2'h2, t});
        stall <= 1'b0;
        repeat (3) begin
            take(w);
            chk(w, nz(s));
            s = nx(s);
        end
        // Enable low freezes the tick out, nothing is sent
        ce <= 1'b0;
        tick();
        repeat (4) @(posedge aclk);
        chk({63'h0, tone_valid}, 64'h0);
        ce <= 1'b1;
        wr(ttg_pkg::CTRL_OFS, 32'h0000_06F1, r);
        tick();
        take(w);
        chk(w, 64'h0);
        // Sine: the phase moves, so neighbouring words differ
        wr(ttg_pkg::CTRL_OFS, 32'h0000_04A1, r);
        wr(ttg_pkg::SINE0_OFS, 32'hFFFF_01C0, r);
        tick();
        take(w);
        tick();
        take(w2);
        chk({63'h0, w.left === w2.left}, 64'h0);
        chk({32'h0, w2.left}, 64'h0000_0000_7FFE_0000);
        rd(ttg_pkg::COUNT_OFS, d, r);
        chk({32'h0, d}, 64'h0000_0000_0000_0007);
        print_verdict();
    end
endmodule
`default_nettype wire
